// *** rtl/imcr_params.svh ***
// constants of the measurement control register set: offsets, fields, resets
// assumes inclusion by bare name from files under rtl/
`ifndef IMCR_PARAMS_SVH
`define IMCR_PARAMS_SVH
// Summary of operation
// - control bit 0 powers device on, resets zero
// - control bit 1 enables temperature sensor
// - control bit 2 enables current amplifier
// - control bit 3 enables voltage amplifier
// - control bit 4 switches converter reference on
// - control bit 5 enables over-current detector
// - control bit 6 routes detector to auxiliary pair
// - gain bits 4:0 current code, gain 2c+2
// - gain bits 7:6 voltage code, gain 2c+2
// - three-bit mux select, codes 6-7 reserved
// - armed conversion starts at select falling edge while control bit 0 is set
// - temperature above limit flags over-temperature while control bit 1 is set
// - enable bit 0 gates over-temperature interrupt
// - enable bit 1 gates under-voltage interrupt
// - enable bit 2 gates over-current interrupt
// - source flags hold until status read
// - interrupt readable and on active-low pin

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define IMCR_ADDR_CTRL     7'h01
`define IMCR_ADDR_GAIN     7'h02
`define IMCR_ADDR_MUX      7'h03
`define IMCR_ADDR_OTLIM    7'h04
`define IMCR_ADDR_IRQEN    7'h05
`define IMCR_ADDR_CURRMSB  7'h10
`define IMCR_ADDR_IRQST    7'h17

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define IMCR_RST_CTRL      8'h00
`define IMCR_RST_GAIN      8'h00
`define IMCR_RST_MUX       8'h00
`define IMCR_RST_OTLIM     8'hFF
`define IMCR_RST_IRQEN     8'h00
`define IMCR_MASK_CTRL     8'h7F
`define IMCR_MASK_GAIN     8'hDF
`define IMCR_MASK_MUX      8'h17
`define IMCR_MASK_IRQEN    8'h07

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define IMCR_CTRL_CHIP     0
`define IMCR_MUX_ADC       4
`define IMCR_IRQ_OT        0
`define IMCR_IRQ_UV        1
`define IMCR_IRQ_OC        2
`define IMCR_DET_INT       5
`define IMCR_DET_WARN      6

// ----------------------------------------------------------------
// serial frame bit counts
// ----------------------------------------------------------------
`define IMCR_CMD_BITS      5'h08
`define IMCR_FRAME_BITS    5'h10
`endif

// *** rtl/imcr_pkg.sv ***
// types shared by the measurement control register set
// assumes no other package
package imcr_pkg;
   // serial port frame states
   typedef enum logic [0:0] {
      SPI_IDLE,
      SPI_SHIFT
   } imcr_spi_state_t;

   // converter input selections
   typedef enum logic [2:0] {
      MUX_CURR_AMP, MUX_VOLT_AMP, MUX_AUX_TWO, MUX_SUPPLY,
      MUX_RAW_CURR, MUX_AUX_ONE, MUX_RSV_6, MUX_RSV_7
   } imcr_mux_sel_t;

   // amplifier gain from its code: twice the code plus two
   function automatic logic [6:0] imcr_gain(input logic [4:0] code);
      imcr_gain = {1'b0, code, 1'b0} + 7'h02;
   endfunction : imcr_gain
endpackage : imcr_pkg

// *** rtl/imcr_irq_if.sv ***
// carrier between register logic and interrupt flag logic
// assumes both ends run on the system clock
`timescale 1ns/10ps
interface imcr_irq_if;
   logic [7:0] temp;
   logic       temp_en;
   logic [7:0] limit;
   logic       uv_evt;
   logic       oc_evt;
   logic       oc_en;
   logic [2:0] enable;
   logic       clear;
   logic [2:0] flags;
   logic       irq_n;
   modport regs (output temp, temp_en, limit, uv_evt, oc_evt, oc_en, enable, clear,
                 input flags, irq_n);
   modport irq  (input temp, temp_en, limit, uv_evt, oc_evt, oc_en, enable, clear,
                 output flags, irq_n);
endinterface : imcr_irq_if

// *** rtl/imcr_sync.sv ***
// two-flop synchroniser for a group of independent levels
// assumes each bit is a slow level or a clock far below clk_in
`timescale 1ns/10ps
module imcr_sync #(
   parameter int unsigned W         = 1,
   parameter logic [W-1:0] RST_VAL  = '0
) (
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // first stage feeds only the second
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= d_in;
         sync_q <= meta_q;
      end
   end
   assign q_out = sync_q;
endmodule : imcr_sync

// *** rtl/imcr_irq.sv ***
// sticky event flags, enable gating and active-low interrupt pin
// assumes events already on the system clock; clear is a one-cycle pulse
`timescale 1ns/10ps
`include "imcr_params.svh"
module imcr_irq (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   imcr_irq_if.irq   ib
);
   logic [2:0] flags_q;
   logic [2:0] flags_d;
   logic [2:0] events;

   // new events win over a clear in the same cycle
   always_comb begin
      events = 3'h0;
      events[`IMCR_IRQ_OT] = ib.temp_en && (ib.temp > ib.limit);
      events[`IMCR_IRQ_UV] = ib.uv_evt;
      events[`IMCR_IRQ_OC] = ib.oc_en && ib.oc_evt;
      flags_d = (flags_q & ~{3{ib.clear}}) | events;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) flags_q <= 3'h0;
      else flags_q <= flags_d;
   end

   // pin low while any enabled flag stands
   assign ib.flags = flags_q;
   assign ib.irq_n = ~|(flags_q & ib.enable);

   property p_overtemp;
      @(posedge clk_in) disable iff (!rst_n_in)
         (ib.temp_en && ib.temp > ib.limit) |=> flags_q[`IMCR_IRQ_OT];
   endproperty
   a_overtemp: assert property (p_overtemp) else $error("over-temp not flagged");

   property p_hold;
      @(posedge clk_in) disable iff (!rst_n_in)
         !ib.clear |=> ((flags_q & $past(flags_q)) == $past(flags_q));
   endproperty
   a_hold: assert property (p_hold) else $error("flag dropped without read");

   property p_irq_assert;
      @(posedge clk_in) disable iff (!rst_n_in)
         (events & ib.enable) != 3'h0 |=> !ib.irq_n;
   endproperty
   a_irq_assert: assert property (p_irq_assert) else $error("pin not asserted");

   property p_clear_release;
      @(posedge clk_in) disable iff (!rst_n_in)
         (ib.clear && events == 3'h0) |=> ib.irq_n;
   endproperty
   a_clear_release: assert property (p_clear_release) else $error("pin held");
endmodule : imcr_irq

// *** rtl/imcr_top.sv ***
// measurement front end control registers behind a serial port
// assumes the host drives mode 0 frames: command byte (bit 7 read,
// bits 6:0 address) then one data byte, msb first, select held low
`timescale 1ns/10ps
`include "imcr_params.svh"
module imcr_top (
   input  wire logic       clk_sys_in,
   input  wire logic       rst_n_in,
   input  wire logic       serial_clk_in,
   input  wire logic       serial_select_n_in,
   input  wire logic       serial_data_in,
   output logic            serial_data_out,
   output logic            serial_data_oe_out,
   input  wire logic [7:0] temp_reading_in,
   input  wire logic       under_voltage_in,
   input  wire logic       over_current_in,
   output logic            chip_power_on_out,
   output logic            temp_sensor_en_out,
   output logic            pga_curr_en_out,
   output logic            pga_volt_en_out,
   output logic            adc_ref_en_out,
   output logic            over_current_en_out,
   output logic            over_current_aux_sel_out,
   output logic [6:0]      pga_curr_gain_out,
   output logic [6:0]      pga_volt_gain_out,
   output logic [2:0]      mux_sel_out,
   output logic            mux_reserved_out,
   output logic            convert_start_out,
   output logic [2:0]      convert_sel_out,
   output logic            irq_n_out
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic       rst_n;

   // assert at once, release after two clock edges
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) rst_sync_q <= 2'h0;
      else rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [4:0] pins_s;
   logic       sck_s;
   logic       sel_n_s;
   logic       mosi_s;
   logic       sck_prev_q;
   logic       sel_prev_q;

   // select idles high so the synchroniser resets deselected
   imcr_sync #(
      .W       (5),
      .RST_VAL (5'h02)
   ) u_sync (
      .clk_in   (clk_sys_in),
      .rst_n_in (rst_n),
      .d_in     ({over_current_in, under_voltage_in, serial_data_in,
                  serial_select_n_in, serial_clk_in}),
      .q_out    (pins_s)
   );
   assign sck_s   = pins_s[0];
   assign sel_n_s = pins_s[1];
   assign mosi_s  = pins_s[2];

   // previous samples for edge detection
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         sck_prev_q <= 1'b0;
         sel_prev_q <= 1'b1;
      end else begin
         sck_prev_q <= sck_s;
         sel_prev_q <= sel_n_s;
      end
   end

   logic sck_rise;
   logic sck_fall;
   logic sel_fall;
   assign sck_rise = sck_s & ~sck_prev_q;
   assign sck_fall = ~sck_s & sck_prev_q;
   assign sel_fall = ~sel_n_s & sel_prev_q;

   // ----------------------------------------------------------------
   // serial frame engine
   // ----------------------------------------------------------------
   imcr_pkg::imcr_spi_state_t st_q;
   imcr_pkg::imcr_spi_state_t st_d;
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   logic [7:0] sh_q;
   logic [7:0] sh_d;
   logic [7:0] cmd_q;
   logic [7:0] cmd_d;
   logic [7:0] tx_q;
   logic [7:0] tx_d;
   logic       wr_q;
   logic       wr_d;
   logic       rdd_q;
   logic       rdd_d;
   logic [7:0] rdata;
   logic [6:0] addr;

   assign addr = cmd_q[6:0];

   // sample on rising clock, shift read data out on falling clock
   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      sh_d  = sh_q;
      cmd_d = cmd_q;
      tx_d  = tx_q;
      wr_d  = 1'b0;
      rdd_d = 1'b0;
      case (st_q)
         imcr_pkg::SPI_IDLE: begin
            if (sel_fall) begin
               st_d  = imcr_pkg::SPI_SHIFT;
               cnt_d = 5'h00;
               tx_d  = 8'h00;
            end
         end
         imcr_pkg::SPI_SHIFT: begin
            if (sel_n_s) begin
               st_d = imcr_pkg::SPI_IDLE;
            end else if (sck_rise && cnt_q != `IMCR_FRAME_BITS) begin
               sh_d  = {sh_q[6:0], mosi_s};
               cnt_d = cnt_q + 5'h01;
               if (cnt_q == `IMCR_CMD_BITS - 5'h01) cmd_d = {sh_q[6:0], mosi_s};
               if (cnt_q == `IMCR_FRAME_BITS - 5'h01) begin
                  wr_d  = ~cmd_q[7];
                  rdd_d = cmd_q[7];
               end
            end else if (sck_fall) begin
               if (cnt_q == `IMCR_CMD_BITS) tx_d = rdata;
               else if (cnt_q > `IMCR_CMD_BITS) tx_d = {tx_q[6:0], 1'b0};
            end
         end
         default: st_d = imcr_pkg::SPI_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         st_q  <= imcr_pkg::SPI_IDLE;
         cnt_q <= 5'h00;
         sh_q  <= 8'h00;
         cmd_q <= 8'h00;
         tx_q  <= 8'h00;
         wr_q  <= 1'b0;
         rdd_q <= 1'b0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         sh_q  <= sh_d;
         cmd_q <= cmd_d;
         tx_q  <= tx_d;
         wr_q  <= wr_d;
         rdd_q <= rdd_d;
      end
   end

   // data pin driven only while selected
   assign serial_data_out    = tx_q[7];
   assign serial_data_oe_out = ~sel_n_s;

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [7:0] gain_q;
   logic [7:0] gain_d;
   logic [7:0] mux_q;
   logic [7:0] mux_d;
   logic [7:0] otlim_q;
   logic [7:0] otlim_d;
   logic [7:0] irqen_q;
   logic [7:0] irqen_d;
   logic       conv_q;
   logic       conv_d;
   logic [2:0] csel_q;
   logic [2:0] csel_d;

   // write at frame end; conversion starts on an armed select fall while control bit 0 is set
   always_comb begin
      ctrl_d  = ctrl_q;
      gain_d  = gain_q;
      mux_d   = mux_q;
      otlim_d = otlim_q;
      irqen_d = irqen_q;
      if (wr_q) begin
         case (addr)
            `IMCR_ADDR_CTRL:  ctrl_d  = sh_q & `IMCR_MASK_CTRL;
            `IMCR_ADDR_GAIN:  gain_d  = sh_q & `IMCR_MASK_GAIN;
            `IMCR_ADDR_MUX:   mux_d   = sh_q & `IMCR_MASK_MUX;
            `IMCR_ADDR_OTLIM: otlim_d = sh_q;
            `IMCR_ADDR_IRQEN: irqen_d = sh_q & `IMCR_MASK_IRQEN;
            default: ;
         endcase
      end
      conv_d = sel_fall && mux_q[`IMCR_MUX_ADC] && ctrl_q[`IMCR_CTRL_CHIP];
      csel_d = mux_q[2:0];
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q  <= `IMCR_RST_CTRL;
         gain_q  <= `IMCR_RST_GAIN;
         mux_q   <= `IMCR_RST_MUX;
         otlim_q <= `IMCR_RST_OTLIM;
         irqen_q <= `IMCR_RST_IRQEN;
         conv_q  <= 1'b0;
         csel_q  <= 3'h0;
      end else begin
         ctrl_q  <= ctrl_d;
         gain_q  <= gain_d;
         mux_q   <= mux_d;
         otlim_q <= otlim_d;
         irqen_q <= irqen_d;
         conv_q  <= conv_d;
         csel_q  <= csel_d;
      end
   end

   // block enables straight from the control register
   assign chip_power_on_out        = ctrl_q[0];
   assign temp_sensor_en_out       = ctrl_q[1];
   assign pga_curr_en_out          = ctrl_q[2];
   assign pga_volt_en_out          = ctrl_q[3];
   assign adc_ref_en_out           = ctrl_q[4];
   assign over_current_en_out      = ctrl_q[5];
   assign over_current_aux_sel_out = ctrl_q[6];

   // gains, input select and conversion start
   assign pga_curr_gain_out = imcr_pkg::imcr_gain(gain_q[4:0]);
   assign pga_volt_gain_out = imcr_pkg::imcr_gain({3'h0, gain_q[7:6]});
   assign mux_sel_out       = mux_q[2:0];
   assign mux_reserved_out  = mux_q[2] & mux_q[1];
   assign convert_start_out = conv_q;
   assign convert_sel_out   = csel_q;

   // ----------------------------------------------------------------
   // interrupt flags and read-back
   // ----------------------------------------------------------------
   imcr_irq_if irq_bus ();

   assign irq_bus.temp    = temp_reading_in;
   assign irq_bus.temp_en = ctrl_q[1];
   assign irq_bus.limit   = otlim_q;
   assign irq_bus.uv_evt  = pins_s[3];
   assign irq_bus.oc_evt  = pins_s[4];
   assign irq_bus.oc_en   = ctrl_q[5];
   assign irq_bus.enable  = irqen_q[2:0];
   assign irq_bus.clear   = rdd_q && (addr == `IMCR_ADDR_IRQST);

   imcr_irq u_irq (
      .clk_in   (clk_sys_in),
      .rst_n_in (rst_n),
      .ib       (irq_bus)
   );

   assign irq_n_out = irq_bus.irq_n;

   // read data for the addressed register
   always_comb begin
      case (addr)
         `IMCR_ADDR_CTRL:    rdata = ctrl_q;
         `IMCR_ADDR_GAIN:    rdata = gain_q;
         `IMCR_ADDR_MUX:     rdata = mux_q;
         `IMCR_ADDR_OTLIM:   rdata = otlim_q;
         `IMCR_ADDR_IRQEN:   rdata = irqen_q;
         `IMCR_ADDR_CURRMSB: rdata = {1'b0, |irq_bus.flags, ~irq_bus.irq_n, 5'h00};
         `IMCR_ADDR_IRQST:   rdata = {5'h00, irq_bus.flags};
         default:            rdata = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [6:0] wr_ctrl_bits;
   logic [4:0] wr_curr_code;
   logic [1:0] wr_volt_code;
   logic [2:0] wr_mux_code;
   logic [2:0] mux_now;
   assign wr_ctrl_bits = sh_q[6:0];
   assign wr_curr_code = sh_q[4:0];
   assign wr_volt_code = sh_q[7:6];
   assign wr_mux_code  = sh_q[2:0];
   assign mux_now      = mux_q[2:0];

   property p_ctrl_write;
      @(posedge clk_sys_in) disable iff (!rst_n)
         (wr_q && addr == `IMCR_ADDR_CTRL) |=>
            ({over_current_aux_sel_out, over_current_en_out, adc_ref_en_out,
              pga_volt_en_out, pga_curr_en_out, temp_sensor_en_out,
              chip_power_on_out} == $past(wr_ctrl_bits));
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control not applied");

   property p_gain_write;
      @(posedge clk_sys_in) disable iff (!rst_n)
         (wr_q && addr == `IMCR_ADDR_GAIN) |=>
            (pga_curr_gain_out == {1'b0, $past(wr_curr_code), 1'b0} + 7'h02) &&
            (pga_volt_gain_out == {4'h0, $past(wr_volt_code), 1'b0} + 7'h02);
   endproperty
   a_gain_write: assert property (p_gain_write) else $error("gain wrong");

   property p_mux_write;
      @(posedge clk_sys_in) disable iff (!rst_n)
         (wr_q && addr == `IMCR_ADDR_MUX) |=>
            (mux_sel_out == $past(wr_mux_code)) &&
            (mux_reserved_out == ($past(wr_mux_code) >= 3'h6));
   endproperty
   a_mux_write: assert property (p_mux_write) else $error("mux select wrong");

   property p_convert;
      @(posedge clk_sys_in) disable iff (!rst_n)
         (sel_fall && mux_q[`IMCR_MUX_ADC] && chip_power_on_out) |=>
            (convert_start_out && convert_sel_out == $past(mux_now)) ##1 !convert_start_out;
   endproperty
   a_convert: assert property (p_convert) else $error("conversion not started");

   property p_detect_read;
      @(posedge clk_sys_in) disable iff (!rst_n)
         (st_q == imcr_pkg::SPI_SHIFT && sck_fall && cnt_q == `IMCR_CMD_BITS &&
          addr == `IMCR_ADDR_CURRMSB) |=> (tx_q[`IMCR_DET_INT] != $past(irq_n_out));
   endproperty
   a_detect_read: assert property (p_detect_read) else $error("detected bit wrong");
endmodule : imcr_top

// *** tb/imcr_host_model.sv ***
// host side model: mode 0 serial frames with a 160 ns serial clock
// assumes the device answers msb first in the second byte of a frame
`timescale 1ns/10ps
module imcr_host_model (
   input  wire logic clk_in,
   output logic      sclk_out,
   output logic      sel_n_out,
   output logic      mosi_out,
   input  wire logic miso_in
);
   // idle: clock low and still, select high
   initial begin
      sclk_out  = 1'b0;
      sel_n_out = 1'b1;
      mosi_out  = 1'b1;
   end

   // one frame; fewer than 16 bits aborts it by raising select early
   task automatic xfer(input logic [15:0] f, input int nbits, output logic [7:0] rd);
      // every later step is a multiple of four clocks, so all stay on falling edges
      @(negedge clk_in);
      sel_n_out = 1'b0;
      #80;
      for (int i = 15; i >= 16 - nbits; i--) begin
         mosi_out = f[i];
         #80 sclk_out = 1'b1;
         #80;
         if (i < 8) rd[i] = miso_in; // answer bit still stands before the fall
         sclk_out = 1'b0;
      end
      #80 sel_n_out = 1'b1;
      mosi_out = ~mosi_out; // a released line does not keep its last level
      #240;
   endtask : xfer
endmodule : imcr_host_model

// *** tb/tb.sv ***
// self-checking bench for the measurement control register set
// assumes imcr_top and the host model; all traffic goes over the serial port
`timescale 1ns/10ps
module tb;
   logic        clk_sys_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        sclk, sel_n, mosi, miso, miso_oe, irq_n, conv, resv;
   logic [7:0]  temp = 8'h00;
   logic        uv = 1'b0;
   logic        oc = 1'b0;
   logic [6:0]  ctl_o, cg, vg;
   logic [2:0]  msel, csel, conv_sel;
   logic [7:0]  ctl, gain, mux;
   int          fail_count = 0;
   int          cmp_count = 0;
   int          n_conv = 0;
   logic [22:0] rows [11] = '{
      {7'h01, 8'hFF, 8'h7F}, {7'h01, 8'h2A, 8'h2A}, {7'h01, 8'h55, 8'h55},
      {7'h02, 8'hFF, 8'hDF}, {7'h02, 8'h41, 8'h41}, {7'h03, 8'h07, 8'h07},
      {7'h03, 8'h06, 8'h06}, {7'h03, 8'h05, 8'h05}, {7'h04, 8'h3C, 8'h3C},
      {7'h05, 8'hFF, 8'h07}, {7'h07, 8'hAA, 8'h00}};

   // ----------------------------------------------------------------
   // clock, instances, monitors
   // ----------------------------------------------------------------
   always #10 clk_sys_in = ~clk_sys_in;

   imcr_top u_imcr_top (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .serial_clk_in(sclk), .serial_select_n_in(sel_n), .serial_data_in(mosi),
      .serial_data_out(miso), .serial_data_oe_out(miso_oe), .temp_reading_in(temp),
      .under_voltage_in(uv), .over_current_in(oc), .chip_power_on_out(ctl_o[0]),
      .temp_sensor_en_out(ctl_o[1]), .pga_curr_en_out(ctl_o[2]),
      .pga_volt_en_out(ctl_o[3]), .adc_ref_en_out(ctl_o[4]),
      .over_current_en_out(ctl_o[5]), .over_current_aux_sel_out(ctl_o[6]),
      .pga_curr_gain_out(cg), .pga_volt_gain_out(vg), .mux_sel_out(msel),
      .mux_reserved_out(resv), .convert_start_out(conv), .convert_sel_out(csel),
      .irq_n_out(irq_n));

   // a released data line shows the inverse of its last level
   imcr_host_model u_imcr_host_model (.clk_in(clk_sys_in), .sclk_out(sclk),
      .sel_n_out(sel_n), .mosi_out(mosi), .miso_in(miso_oe ? miso : ~miso));

   // counts conversion start pulses and keeps the select sent with them
   always @(negedge clk_sys_in) begin
      if (conv === 1'b1) begin
         n_conv++;
         conv_sel <= csel;
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] rd;
      u_imcr_host_model.xfer({1'b0, a, d}, 16, rd);
   endtask : wr

   task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] rd;
      u_imcr_host_model.xfer({1'b1, a, 8'h00}, 16, rd);
      chk({24'h0, rd}, {24'h0, exp});
   endtask : rdc

   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask : idle

   task automatic give_verdict;
      $display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict

   // expected port values from the register shadows
   function automatic logic [24:0] exp_outs();
      return {ctl[6:0], {1'b0, gain[4:0], 1'b0} + 7'h02, {4'h0, gain[7:6], 1'b0} + 7'h02,
              mux[2:0], mux[2:1] == 2'b11};
   endfunction : exp_outs

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] rd;
      ctl  = 8'h00;
      gain = 8'h00;
      mux  = 8'h00;
      idle(20);
      rst_n_in = 1'b1;
      idle(5);
      chk({7'h0, ctl_o, cg, vg, msel, resv}, {7'h0, exp_outs()});
      chk({30'h0, irq_n, miso_oe}, 32'h2);
      for (int i = 1; i <= 5; i++) rdc(i[6:0], (i == 4) ? 8'hFF : 8'h00);
      // table of writes, read-backs and port values
      foreach (rows[i]) begin
         wr(rows[i][22:16], rows[i][15:8]);
         rdc(rows[i][22:16], rows[i][7:0]);
         case (rows[i][22:16])
            7'h01: ctl = rows[i][7:0];
            7'h02: gain = rows[i][7:0];
            7'h03: mux = rows[i][7:0];
            default: ;
         endcase
         chk({7'h0, ctl_o, cg, vg, msel, resv}, {7'h0, exp_outs()});
      end
      // armed conversion starts at the next select fall only while powered
      wr(7'h01, 8'h01);
      wr(7'h03, 8'h13);
      n_conv = 0;
      rdc(7'h03, 8'h13);
      chk(n_conv, 1);
      chk({29'h0, conv_sel}, 32'h3);
      wr(7'h01, 8'h00);
      n_conv = 0;
      rdc(7'h03, 8'h13);
      chk(n_conv, 0);
      wr(7'h03, 8'h00);
      // over-temperature: equal is no event, above is
      wr(7'h01, 8'h23);
      wr(7'h04, 8'h80);
      wr(7'h05, 8'h07);
      rdc(7'h17, 8'h00);
      temp = 8'h80;
      idle(8);
      chk({31'h0, irq_n}, 32'h1);
      temp = 8'h81;
      idle(8);
      chk({31'h0, irq_n}, 32'h0);
      temp = 8'h00;
      idle(8);
      chk({31'h0, irq_n}, 32'h0);
      rdc(7'h10, 8'h60);
      rdc(7'h17, 8'h01);
      chk({31'h0, irq_n}, 32'h1);
      // under-voltage flagged but masked
      wr(7'h05, 8'h05);
      uv = 1'b1;
      idle(8);
      uv = 1'b0;
      idle(4);
      chk({31'h0, irq_n}, 32'h1);
      rdc(7'h10, 8'h40);
      rdc(7'h17, 8'h02);
      // over-current enabled
      wr(7'h05, 8'h07);
      oc = 1'b1;
      idle(8);
      oc = 1'b0;
      idle(4);
      chk({31'h0, irq_n}, 32'h0);
      rdc(7'h17, 8'h04);
      chk({31'h0, irq_n}, 32'h1);
      // frame aborted by select leaves the limit untouched
      u_imcr_host_model.xfer({1'b0, 7'h04, 8'h11}, 12, rd);
      rdc(7'h04, 8'h80);
      // mid-run reset returns every register to its default
      rst_n_in = 1'b0;
      idle(2);
      rst_n_in = 1'b1;
      ctl  = 8'h00;
      gain = 8'h00;
      mux  = 8'h00;
      idle(5);
      chk({7'h0, ctl_o, cg, vg, msel, resv}, {7'h0, exp_outs()});
      chk({30'h0, irq_n, miso_oe}, 32'h2);
      rdc(7'h04, 8'hFF);
      rdc(7'h05, 8'h00);
      give_verdict();
   end

   // watchdog well beyond the expected run of about 150 us
   initial begin
      #500000;
      fail_count++;
      give_verdict();
   end
endmodule : tb
